//--- core/file_arbiter.sv
// Purpose: Tie-breaker for file writes from the host and the microprocessor.
// Assumes: Each side holds at most one deferred write at a time.
// Notes: A deferred write goes first on its next chance, so it is never starved.
`timescale 1ns/100ps

module file_arbiter
  import hpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input file_req_t hostReq,
  input file_req_t mpuReq,
  output file_req_t wrPort
);
  file_req_t hostPend_ff;
  file_req_t mpuPend_ff;
  file_req_t hostCand;
  file_req_t mpuCand;
  logic mpuPrio_ff;
  logic contest;
  logic hostWin;
  logic mpuWin;

  // Pick a winner; on a clash the side that lost last time wins.
  always_comb
  begin
    hostCand = hostPend_ff.valid ? hostPend_ff : hostReq;
    mpuCand = mpuPend_ff.valid ? mpuPend_ff : mpuReq;
    contest = hostCand.valid & mpuCand.valid;
    hostWin = hostCand.valid & (~contest | ~mpuPrio_ff);
    mpuWin = mpuCand.valid & (~contest | mpuPrio_ff);
    wrPort = hostWin ? hostCand : mpuCand;
    wrPort.valid = hostWin | mpuWin;
  end

  // The loser keeps its write for a later cycle instead of dropping it.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hostPend_ff <= '0;
      mpuPend_ff <= '0;
    end
    else
    begin
      hostPend_ff <= hostWin ? (hostPend_ff.valid ? hostReq : '0) : hostCand;
      mpuPend_ff <= mpuWin ? (mpuPend_ff.valid ? mpuReq : '0) : mpuCand;
    end
  end

  // Priority flips toward the loser after each clash.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mpuPrio_ff <= 1'b0;
    end
    else if (contest)
    begin
      mpuPrio_ff <= hostWin;
    end
  end
endmodule

//--- core/file_ram.sv
// Purpose: Shared parameter and drive status file, one write and two read ports.
// Assumes: Write port is fed by the arbiter; reads never collide.
// Notes: Read data are registered and valid the cycle after the address.
`timescale 1ns/100ps

module file_ram
  import hpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input file_req_t wrPort,
  input wire logic [FILE_AW-1:0] rdAddrA,
  input wire logic [FILE_AW-1:0] rdAddrB,
  output logic [DATA_W-1:0] rdDataA,
  output logic [DATA_W-1:0] rdDataB
);
  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // Storage array, written once per cycle at most.
  always_ff @(posedge sys_clk)
  begin
    if (wrPort.valid)
    begin
      mem[wrPort.addr] <= wrPort.data;
    end
  end

  // Registered read ports.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rdDataA <= '0;
      rdDataB <= '0;
    end
    else
    begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
    end
  end
endmodule

//--- core/host_port_adapter.sv
// Purpose: Port adapter between a host bus and the disk controller microprocessor.
// Assumes: Both ports are synchronous to sys_clk; busInit is a synchronous level.
// Notes: Both ports answer reads one cycle later and never stall.
`timescale 1ns/100ps

module host_port_adapter
  import hpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [BUS_AW-1:0] hostAddr,
  input wire logic [DATA_W-1:0] hostWdata,
  input wire logic hostWr,
  input wire logic hostRd,
  output logic [DATA_W-1:0] hostRdata,
  input wire logic [BUS_AW-1:0] mpuAddr,
  input wire logic [DATA_W-1:0] mpuWdata,
  input wire logic mpuWr,
  input wire logic mpuRd,
  output logic [DATA_W-1:0] mpuRdata,
  input wire logic busInit,
  output logic hostIrq,
  output logic [VEC_W-1:0] hostVector,
  output logic mpuIrq,
  input wire logic dmaWordReq,
  input wire logic otherNpr,
  input wire logic otherBr,
  input wire logic nprGrant,
  output logic nprReq,
  output logic dmaWordAck
);
  logic busInitPrev_ff;
  logic [UNIT_W-1:0] hostUnit_ff;
  logic [UNIT_W-1:0] mpuUnit_ff;
  logic ready_ff;
  logic [NUM_DRIVES-1:0] go_ff;
  logic [FUNC_W-1:0] func_ff;
  logic ie_ff;
  logic [IRQ_W-1:0] irqSt_ff;
  logic [IRQ_W-1:0] irqMask_ff;
  logic [FLAG_W-1:0] mpuFlags_ff;
  logic [EVCODE_W-1:0] evCode_ff;
  logic [VEC_W-1:0] vecBase_ff;
  logic [VEC_W-1:0] hostVector_ff;
  logic [BURST_W-1:0] burstSel_ff;
  logic [BCNT_W-1:0] burstCnt_ff;
  dma_state_t dmaState_ff;
  logic hostFileSel_ff;
  logic mpuFileSel_ff;
  logic [DATA_W-1:0] hostDisc_ff;
  logic [DATA_W-1:0] mpuDisc_ff;
  logic [DATA_W-1:0] hostDisc;
  logic [DATA_W-1:0] mpuDisc;
  logic [DATA_W-1:0] ramRdA;
  logic [DATA_W-1:0] ramRdB;
  logic [BUS_AW-1:0] hostRel;
  logic [BUS_AW-1:0] mpuRel;
  logic [FILE_AW-1:0] hostFileAddr;
  logic [FILE_AW-1:0] mpuFileAddr;
  logic hostIsFile;
  logic mpuIsFile;
  logic hostCs1Wr;
  logic hostGo;
  logic hostCs2Wr;
  logic hostResetCmd;
  logic hostFileWr;
  logic mpuCs1Wr;
  logic mpuRdyWr;
  logic mpuFileWr;
  logic mpuStatusWr;
  logic mpuEvWr;
  logic cmdDone;
  logic initEdge;
  logic progErr;
  logic [IRQ_W-1:0] irqSet;
  logic [FLAG_W-1:0] flagSet;
  logic [BCNT_W-1:0] burstLimit;
  file_req_t hostFileReq;
  file_req_t mpuFileReq;
  file_req_t wrPort;

  // Compose control_status_one for the given unit.
  function automatic logic [DATA_W-1:0] cs1Of(input logic [UNIT_W-1:0] unit);
    logic [DATA_W-1:0] v;
    v = '0;
    v[CS1_GO] = go_ff[unit];
    v[CS1_FUNC_LSB +: FUNC_W] = func_ff;
    v[CS1_IE] = ie_ff;
    v[CS1_RDY] = ready_ff;
    v[CS1_PGE] = irqSt_ff[IRQ_PGE];
    v[CS1_CCP] = irqSt_ff[IRQ_CMD];
    v[CS1_EVP] = irqSt_ff[IRQ_EVT] & ~irqSt_ff[IRQ_CMD];
    return v;
  endfunction

  // Compose control_status_two for the given unit.
  function automatic logic [DATA_W-1:0] cs2Of(input logic [UNIT_W-1:0] unit);
    logic [DATA_W-1:0] v;
    v = '0;
    v[CS2_UNIT_SELECT_REG_LSB +: UNIT_W] = unit;
    v[CS2_BURST_LSB +: BURST_W] = burstSel_ff;
    v[CS2_EVCODE_LSB +: EVCODE_W] = evCode_ff;
    return v;
  endfunction

  // Address decode of both ports; file words map into the selected drive record.
  assign hostRel = hostAddr - FILE_BASE_OFS;
  assign mpuRel = mpuAddr - FILE_BASE_OFS;
  assign hostIsFile = (hostAddr >= FILE_BASE_OFS) && (hostAddr <= FILE_LAST_OFS);
  assign mpuIsFile = (mpuAddr >= FILE_BASE_OFS) && (mpuAddr <= FILE_LAST_OFS);
  assign hostFileAddr = {hostUnit_ff, hostRel[IDX_W-1:0]};
  assign mpuFileAddr = {mpuUnit_ff, mpuRel[IDX_W-1:0]};

  // Write strobes and the events they cause.
  assign hostCs1Wr = hostWr && (hostAddr == HOST_CS1_OFS);
  assign hostGo = hostCs1Wr && hostWdata[CS1_GO];
  assign hostCs2Wr = hostWr && (hostAddr == HOST_CS2_OFS);
  assign hostResetCmd = hostCs2Wr && hostWdata[CS2_RESET];
  assign hostFileWr = hostWr && hostIsFile;
  assign mpuCs1Wr = mpuWr && (mpuAddr == MPU_CS1_OFS);
  assign mpuRdyWr = mpuCs1Wr && mpuWdata[CS1_RDY];
  assign mpuFileWr = mpuWr && mpuIsFile;
  assign mpuStatusWr = mpuFileWr && (mpuRel[IDX_W-1:0] == IDX_DRIVE_STATUS);
  assign mpuEvWr = mpuWr && (mpuAddr == MPU_EVCODE_OFS);
  assign cmdDone = mpuStatusWr | mpuRdyWr;
  assign initEdge = busInit & ~busInitPrev_ff;
  assign progErr = (hostGo | hostFileWr) & ~ready_ff;

  // File write requests toward the arbiter.
  assign hostFileReq = '{valid: hostFileWr, addr: hostFileAddr, data: hostWdata};
  assign mpuFileReq = '{valid: mpuFileWr, addr: mpuFileAddr, data: mpuWdata};

  file_arbiter u_arb (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .hostReq(hostFileReq),
    .mpuReq(mpuFileReq),
    .wrPort(wrPort)
  );

  file_ram u_ram (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wrPort(wrPort),
    .rdAddrA(hostFileAddr),
    .rdAddrB(mpuFileAddr),
    .rdDataA(ramRdA),
    .rdDataB(ramRdB)
  );

  // Leading-edge detector for the host bus initialize.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busInitPrev_ff <= 1'b0;
    end
    else
    begin
      busInitPrev_ff <= busInit;
    end
  end

  // Unit selects of both sides, the DMA burst choice and the vector base.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hostUnit_ff <= '0;
      mpuUnit_ff <= '0;
      burstSel_ff <= BURST_RST;
      vecBase_ff <= VEC_BASE_RST;
    end
    else
    begin
      if (hostCs2Wr)
      begin
        hostUnit_ff <= hostWdata[CS2_UNIT_SELECT_REG_LSB +: UNIT_W];
        burstSel_ff <= hostWdata[CS2_BURST_LSB +: BURST_W];
      end
      if (mpuWr && (mpuAddr == MPU_CS2_OFS))
      begin
        mpuUnit_ff <= mpuWdata[CS2_UNIT_SELECT_REG_LSB +: UNIT_W];
      end
      if (hostWr && (hostAddr == HOST_VEC_OFS))
      begin
        vecBase_ff <= hostWdata[VEC_W-1:0];
      end
    end
  end

  // Ready: initialize and completion set it, a host go clears it; set wins.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ready_ff <= RDY_RST;
    end
    else if (initEdge || cmdDone)
    begin
      ready_ff <= 1'b1;
    end
    else if (hostGo)
    begin
      ready_ff <= 1'b0;
    end
  end

  // One go bit per drive, set by the host, cleared by the status post.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      go_ff <= '0;
    end
    else if (initEdge)
    begin
      go_ff <= '0;
    end
    else
    begin
      if (mpuStatusWr)
      begin
        go_ff[mpuUnit_ff] <= 1'b0;
      end
      if (hostGo)
      begin
        go_ff[hostUnit_ff] <= 1'b1;
      end
    end
  end

  // Function code and interrupt enable; initialize resets the enable.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      func_ff <= '0;
      ie_ff <= 1'b0;
    end
    else if (initEdge)
    begin
      ie_ff <= 1'b0;
    end
    else if (hostCs1Wr)
    begin
      func_ff <= hostWdata[CS1_FUNC_LSB +: FUNC_W];
      ie_ff <= hostWdata[CS1_IE];
    end
  end

  // Event code written by the microprocessor for event interrupts.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      evCode_ff <= '0;
    end
    else if (mpuEvWr)
    begin
      evCode_ff <= mpuWdata[EVCODE_W-1:0];
    end
  end

  // Host interrupt status: sticky, write one to clear, a new event beats the clear.
  always_comb
  begin
    irqSet = '0;
    irqSet[IRQ_CMD] = cmdDone;
    irqSet[IRQ_EVT] = mpuEvWr;
    irqSet[IRQ_PGE] = progErr;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || initEdge)
    begin
      irqSt_ff <= '0;
    end
    else if (hostWr && (hostAddr == HOST_IRQ_ST_OFS))
    begin
      irqSt_ff <= (irqSt_ff & ~hostWdata[IRQ_W-1:0]) | irqSet;
    end
    else
    begin
      irqSt_ff <= irqSt_ff | irqSet;
    end
  end

  // Host interrupt mask.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      irqMask_ff <= '0;
    end
    else if (hostWr && (hostAddr == HOST_IRQ_MASK_OFS))
    begin
      irqMask_ff <= hostWdata[IRQ_W-1:0];
    end
  end

  // Vector follows the highest pending cause: command before event.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hostVector_ff <= VEC_BASE_RST;
    end
    else
    begin
      hostVector_ff <= irqSt_ff[IRQ_CMD] ? vecBase_ff : vecBase_ff + VEC_EVT_OFS;
    end
  end

  // Microprocessor event flags: sticky, write one to clear, set wins.
  always_comb
  begin
    flagSet = '0;
    flagSet[FLAG_CMD] = hostGo;
    flagSet[FLAG_RST] = hostResetCmd;
    flagSet[FLAG_SR] = initEdge;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mpuFlags_ff <= '0;
    end
    else if (mpuWr && (mpuAddr == MPU_FLAGS_OFS))
    begin
      mpuFlags_ff <= (mpuFlags_ff & ~mpuWdata[FLAG_W-1:0]) | flagSet;
    end
    else
    begin
      mpuFlags_ff <= mpuFlags_ff | flagSet;
    end
  end

  // Discrete read values of both ports; unmapped words read zero.
  always_comb
  begin
    case (hostAddr)
      HOST_CS1_OFS: hostDisc = cs1Of(hostUnit_ff);
      HOST_CS2_OFS: hostDisc = cs2Of(hostUnit_ff);
      HOST_VEC_OFS: hostDisc = DATA_W'(vecBase_ff);
      HOST_IRQ_ST_OFS: hostDisc = DATA_W'(irqSt_ff);
      HOST_IRQ_MASK_OFS: hostDisc = DATA_W'(irqMask_ff);
      default: hostDisc = '0;
    endcase
    case (mpuAddr)
      MPU_CS1_OFS: mpuDisc = cs1Of(mpuUnit_ff);
      MPU_CS2_OFS: mpuDisc = cs2Of(mpuUnit_ff);
      MPU_EVCODE_OFS: mpuDisc = DATA_W'(evCode_ff);
      MPU_FLAGS_OFS: mpuDisc = DATA_W'(mpuFlags_ff);
      default: mpuDisc = '0;
    endcase
  end

  // Read data registers; data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hostFileSel_ff <= 1'b0;
      mpuFileSel_ff <= 1'b0;
      hostDisc_ff <= '0;
      mpuDisc_ff <= '0;
    end
    else
    begin
      hostFileSel_ff <= hostRd && hostIsFile;
      mpuFileSel_ff <= mpuRd && mpuIsFile;
      hostDisc_ff <= (hostRd && !hostIsFile) ? hostDisc : '0;
      mpuDisc_ff <= (mpuRd && !mpuIsFile) ? mpuDisc : '0;
    end
  end

  // DMA throttle: a burst of the chosen length, then yield to other requesters.
  assign burstLimit = BCNT_W'((BCNT_W'(1) << burstSel_ff) - BCNT_W'(1));
  assign dmaWordAck = (dmaState_ff == DMA_BURST) && dmaWordReq && nprGrant;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dmaState_ff <= DMA_IDLE;
    end
    else
    begin
      unique case (dmaState_ff)
        DMA_IDLE:
        begin
          if (dmaWordReq)
          begin
            dmaState_ff <= DMA_BURST;
          end
        end
        DMA_BURST:
        begin
          if (dmaWordAck && (burstCnt_ff == burstLimit))
          begin
            dmaState_ff <= DMA_YIELD;
          end
          else if (!dmaWordReq)
          begin
            dmaState_ff <= DMA_IDLE;
          end
        end
        DMA_YIELD:
        begin
          if (!otherNpr && !otherBr)
          begin
            dmaState_ff <= DMA_IDLE;
          end
        end
        default: dmaState_ff <= DMA_IDLE;
      endcase
    end
  end

  // Words moved within the current burst.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (dmaState_ff != DMA_BURST))
    begin
      burstCnt_ff <= '0;
    end
    else if (dmaWordAck)
    begin
      burstCnt_ff <= burstCnt_ff + BCNT_W'(1);
    end
  end

  // Outputs.
  assign hostRdata = hostFileSel_ff ? ramRdA : hostDisc_ff;
  assign mpuRdata = mpuFileSel_ff ? ramRdB : mpuDisc_ff;
  assign hostIrq = ie_ff & |(irqSt_ff & irqMask_ff);
  assign mpuIrq = |mpuFlags_ff;
  assign hostVector = hostVector_ff;
  assign nprReq = (dmaState_ff == DMA_BURST);
endmodule

//--- inc/hpa_pkg.sv
// Purpose: Shared constants, types and register layout of the host port adapter.
// Assumes: One 16-bit word per register, word-indexed addresses on both ports.
// Notes: Bit positions are indices into a 16-bit data word.
package hpa_pkg;
  localparam int DATA_W = 16;
  localparam int BUS_AW = 4;
  localparam int UNIT_W = 3;
  localparam int IDX_W = 2;
  localparam int FILE_AW = UNIT_W + IDX_W;
  localparam int FILE_DEPTH = 32;
  localparam int NUM_DRIVES = 8;

  // Host port register offsets.
  localparam logic [BUS_AW-1:0] HOST_CS1_OFS = 4'h0;
  localparam logic [BUS_AW-1:0] HOST_CS2_OFS = 4'h1;
  localparam logic [BUS_AW-1:0] FILE_BASE_OFS = 4'h2;
  localparam logic [BUS_AW-1:0] FILE_LAST_OFS = 4'h5;
  localparam logic [BUS_AW-1:0] HOST_VEC_OFS = 4'h6;
  localparam logic [BUS_AW-1:0] HOST_IRQ_ST_OFS = 4'h7;
  localparam logic [BUS_AW-1:0] HOST_IRQ_MASK_OFS = 4'h8;

  // Microprocessor port register offsets.
  localparam logic [BUS_AW-1:0] MPU_CS1_OFS = 4'h0;
  localparam logic [BUS_AW-1:0] MPU_CS2_OFS = 4'h1;
  localparam logic [BUS_AW-1:0] MPU_EVCODE_OFS = 4'h6;
  localparam logic [BUS_AW-1:0] MPU_FLAGS_OFS = 4'h7;

  // Word of a drive record that holds the drive status.
  localparam logic [IDX_W-1:0] IDX_DRIVE_STATUS = 2'h2;

  // control_status_one layout.
  localparam int CS1_GO = 0;
  localparam int CS1_FUNC_LSB = 1;
  localparam int FUNC_W = 5;
  localparam int CS1_IE = 6;
  localparam int CS1_RDY = 7;
  localparam int CS1_PGE = 13;
  localparam int CS1_EVP = 14;
  localparam int CS1_CCP = 15;

  // control_status_two layout.
  localparam int CS2_UNIT_SELECT_REG_LSB = 0;
  localparam int CS2_RESET = 5;
  localparam int CS2_BURST_LSB = 8;
  localparam int BURST_W = 2;
  localparam int CS2_EVCODE_LSB = 10;
  localparam int EVCODE_W = 5;

  // Host interrupt status and mask layout.
  localparam int IRQ_W = 3;
  localparam int IRQ_CMD = 0;
  localparam int IRQ_EVT = 1;
  localparam int IRQ_PGE = 2;

  // Microprocessor event flag layout.
  localparam int FLAG_W = 3;
  localparam int FLAG_CMD = 0;
  localparam int FLAG_RST = 1;
  localparam int FLAG_SR = 2;

  // Vector generation, DMA throttle and ready reset value.
  localparam int VEC_W = 8;
  localparam logic [VEC_W-1:0] VEC_EVT_OFS = 8'h04;
  localparam logic [VEC_W-1:0] VEC_BASE_RST = 8'h00;
  localparam int BCNT_W = 4;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic RDY_RST = 1'b1;

  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_BURST = 2'b01,
    DMA_YIELD = 2'b10
  } dma_state_t;

  typedef struct packed {
    logic valid;
    logic [FILE_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_req_t;
endpackage

//--- tb/host_port_adapter_chk.sv
// Purpose: Port checks of the host port adapter.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the adapter at the foot of this file.
`timescale 1ns/100ps

module host_port_adapter_chk
  import hpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [BUS_AW-1:0] hostAddr,
  input wire logic [DATA_W-1:0] hostWdata,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [DATA_W-1:0] hostRdata,
  input wire logic mpuWr,
  input wire logic busInit,
  input wire logic hostIrq,
  input wire logic mpuIrq,
  input wire logic dmaWordReq,
  input wire logic otherNpr,
  input wire logic nprGrant,
  input wire logic nprReq,
  input wire logic dmaWordAck
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  logic goWr;
  logic cs1Rd;

  // Host go write and host read of the first status word.
  assign goWr = hostWr && hostAddr == HOST_CS1_OFS && hostWdata[CS1_GO];
  assign cs1Rd = hostRd && hostAddr == HOST_CS1_OFS;

  // Each property ties a port response to its cause.
  AST_RD_IDLE: assert property (!hostRd |=> hostRdata == '0)
    else $error("read data not idle");
  AST_GO_RDY: assert property (goWr && !mpuWr && !busInit ##1 cs1Rd && !mpuWr
    |=> hostRdata[CS1_GO] && !hostRdata[CS1_RDY])
    else $error("go did not clear ready");
  AST_GO_FLAG: assert property (goWr |=> mpuIrq)
    else $error("go raised no flag");
  AST_INIT_FLAG: assert property ($rose(busInit) |=> mpuIrq)
    else $error("initialize raised no flag");
  AST_INIT_QUIET: assert property ($rose(busInit) |=> !hostIrq)
    else $error("initialize left host interrupt");
  AST_CMD_FIRST: assert property ($past(cs1Rd) && hostRdata[CS1_CCP] |-> !hostRdata[CS1_EVP])
    else $error("event shown over command");
  AST_ACK_GRANT: assert property (dmaWordAck |-> nprReq && dmaWordReq && nprGrant)
    else $error("ack without grant");
  AST_YIELD: assert property ($fell(nprReq) && $past(dmaWordReq) && otherNpr |=> !nprReq)
    else $error("burst did not yield");

  COV_INIT: cover property ($rose(busInit));
  COV_ACK: cover property (dmaWordAck);
  COV_IRQ: cover property ($rose(hostIrq));
endmodule

bind host_port_adapter host_port_adapter_chk u_chk (
  .sys_clk, .sys_rst, .hostAddr, .hostWdata, .hostWr, .hostRd, .hostRdata, .mpuWr,
  .busInit, .hostIrq, .mpuIrq, .dmaWordReq, .otherNpr, .nprGrant, .nprReq, .dmaWordAck
);

//--- tb/host_port_adapter_tb_top.sv
// Purpose: Self-checking bench of the host port adapter.
// Assumes: Host port driven here, microprocessor port by mpu_model.
// Notes: Each scenario task judges its own results.
`timescale 1ns/100ps

module host_port_adapter_tb_top
  import hpa_pkg::*;
  ;
  localparam logic [VEC_W-1:0] VBASE = 8'h40;
  localparam logic [BUS_AW-1:0] STAT = FILE_BASE_OFS + {2'h0, IDX_DRIVE_STATUS};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [BUS_AW-1:0] hostAddr = '0;
  logic [DATA_W-1:0] hostWdata = '0;
  logic hostWr = 1'b0, hostRd = 1'b0, busInit = 1'b0, dmaWordReq = 1'b0;
  logic otherNpr = 1'b0, otherBr = 1'b0, nprGrant = 1'b0, opGo = 1'b0;
  logic [BUS_AW-1:0] opAddr = '0;
  logic [DATA_W-1:0] opData = '0;
  logic [3:0] lag = 4'h0;
  logic [DATA_W-1:0] hostRdata, mpuRdata, mpuWdata;
  logic [BUS_AW-1:0] mpuAddr;
  logic mpuWr, mpuRd, hostIrq, mpuIrq, nprReq, dmaWordAck;
  logic [VEC_W-1:0] hostVector;
  logic [FLAG_W-1:0] seenFlags;
  int miscompares = 0;
  int totalChecks = 0;
  int cyc = 0;

  host_port_adapter dut (.sys_clk, .sys_rst, .hostAddr, .hostWdata, .hostWr, .hostRd, .hostRdata,
    .mpuAddr, .mpuWdata, .mpuWr, .mpuRd, .mpuRdata, .busInit, .hostIrq, .hostVector, .mpuIrq,
    .dmaWordReq, .otherNpr, .otherBr, .nprGrant, .nprReq, .dmaWordAck);
  mpu_model mpu (.sys_clk, .sys_rst, .mpuIrq, .mpuRdata, .lag, .opGo, .opAddr, .opData,
    .mpuAddr, .mpuWdata, .mpuWr, .mpuRd, .seenFlags);

  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;

  // Verdict and end of run.
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares one word.
  task automatic chk(input logic [DATA_W-1:0] g, e);
    totalChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Host write, one strobe cycle.
  task automatic hw(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    hostWr <= 1'b1;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge sys_clk);
    hostWr <= 1'b0;
  endtask

  // Host read; data taken in the answer cycle.
  task automatic hr(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    hostRd <= 1'b1;
    hostAddr <= a;
    @(posedge sys_clk);
    hostRd <= 1'b0;
    #1 d = hostRdata;
  endtask

  // Host read and compare.
  task automatic hc(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    hr(a, d);
    chk(d, e);
  endtask

  // Microprocessor write through the model.
  task automatic op(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    opGo <= 1'b1;
    opAddr <= a;
    opData <= d;
    @(posedge sys_clk);
    opGo <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Waits, bounded, until the model has serviced its interrupt.
  task automatic drain();
    #1;
    for (int i = 0; i < 40 && mpuIrq !== 1'b0; i++)
      @(posedge sys_clk);
  endtask

  // Reset values and an unmapped read.
  task automatic tReset();
    hc(HOST_CS1_OFS, 16'h0080);
    hc(4'hf, 16'h0000);
    chk({8'h00, hostVector}, 16'h0004);
    $display("reset test done");
  endtask

  // Go, busy go, drive status post, per-unit go and records.
  task automatic tCmd();
    hw(HOST_VEC_OFS, {8'h00, VBASE});
    hw(HOST_IRQ_MASK_OFS, 16'h0007);
    @(posedge sys_clk);
    hostWr <= 1'b1;
    hostAddr <= HOST_CS1_OFS;
    hostWdata <= 16'h0043;
    @(posedge sys_clk);
    hostWr <= 1'b0;
    hostRd <= 1'b1;
    @(posedge sys_clk);
    hostRd <= 1'b0;
    #1 chk(hostRdata, 16'h0043);
    drain();
    chk({13'h0, seenFlags}, 16'h0001);
    hw(HOST_CS2_OFS, 16'h0002);
    hw(HOST_CS1_OFS, 16'h0043);
    hc(HOST_IRQ_ST_OFS, 16'h0004);
    drain();
    hw(HOST_CS2_OFS, 16'h0000);
    hc(HOST_CS1_OFS, 16'h2043);
    op(MPU_CS2_OFS, 16'h0000);
    op(STAT, 16'h1234);
    chk({15'h0, hostIrq}, 16'h0001);
    hc(HOST_CS1_OFS, 16'ha0c2);
    chk({8'h00, hostVector}, {8'h00, VBASE});
    hw(HOST_CS2_OFS, 16'h0002);
    hc(HOST_CS1_OFS, 16'ha0c3);
    hw(STAT, 16'h5555);
    hc(STAT, 16'h5555);
    $display("command test done");
  endtask

  // Event code, priority, clearing and masking.
  task automatic tEvt();
    hw(HOST_CS2_OFS, 16'h0000);
    hc(STAT, 16'h1234);
    op(MPU_EVCODE_OFS, 16'h0015);
    chk({8'h00, hostVector}, {8'h00, VBASE});
    hc(HOST_CS2_OFS, 16'h5400);
    hw(HOST_IRQ_ST_OFS, 16'h0001);
    hc(HOST_CS1_OFS, 16'h60c2);
    chk({8'h00, hostVector}, {8'h00, VBASE + VEC_EVT_OFS});
    hw(HOST_IRQ_ST_OFS, 16'h0006);
    #1 chk({15'h0, hostIrq}, 16'h0000);
    hw(HOST_IRQ_MASK_OFS, 16'h0000);
    op(MPU_EVCODE_OFS, 16'h0003);
    chk({15'h0, hostIrq}, 16'h0000);
    hc(HOST_IRQ_ST_OFS, 16'h0002);
    hw(HOST_IRQ_MASK_OFS, 16'h0002);
    #1 chk({15'h0, hostIrq}, 16'h0001);
    $display("event test done");
  endtask

  // Reset command, then initialize with a slow microprocessor.
  task automatic tReinit();
    logic [DATA_W-1:0] d;
    hw(HOST_CS2_OFS, 16'h0020);
    drain();
    chk({13'h0, seenFlags}, 16'h0002);
    hr(HOST_CS2_OFS, d);
    chk(d & 16'h03ff, 16'h0000);
    lag <= 4'h5;
    hw(HOST_CS1_OFS, 16'h0041);
    drain();
    op(MPU_CS1_OFS, 16'h0080);
    hc(HOST_CS1_OFS, 16'h80c1);
    @(posedge sys_clk);
    busInit <= 1'b1;
    repeat (2) @(posedge sys_clk);
    drain();
    busInit <= 1'b0;
    chk({13'h0, seenFlags}, 16'h0004);
    chk({15'h0, hostIrq}, 16'h0000);
    hr(HOST_CS1_OFS, d);
    chk(d & 16'h00c1, 16'h0080);
    hc(HOST_IRQ_ST_OFS, 16'h0000);
    lag <= 4'h0;
    $display("reinit test done");
  endtask

  // File writes from both sides in one cycle, twice.
  task automatic tClash();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      opGo <= 1'b1;
      opAddr <= FILE_BASE_OFS + 4'h1;
      opData <= {12'ha5a, i[3:0]};
      @(posedge sys_clk);
      opGo <= 1'b0;
      hostWr <= 1'b1;
      hostAddr <= FILE_BASE_OFS + 4'h3;
      hostWdata <= {12'h5a5, i[3:0]};
      @(posedge sys_clk);
      hostWr <= 1'b0;
      hc(FILE_BASE_OFS + 4'h1, {12'ha5a, i[3:0]});
      hc(FILE_BASE_OFS + 4'h3, {12'h5a5, i[3:0]});
    end
    $display("clash test done");
  endtask

  // Burst of two words, yield to other requesters, resume.
  task automatic tDma();
    logic [DATA_W-1:0] n;
    hw(HOST_CS2_OFS, 16'h0100);
    @(posedge sys_clk);
    dmaWordReq <= 1'b1;
    nprGrant <= 1'b1;
    otherNpr <= 1'b1;
    otherBr <= 1'b1;
    n = '0;
    repeat (12)
    begin
      @(posedge sys_clk);
      #1 n = n + {15'h0, dmaWordAck};
    end
    chk(n, 16'h0002);
    chk({15'h0, nprReq}, 16'h0000);
    @(posedge sys_clk);
    otherNpr <= 1'b0;
    otherBr <= 1'b0;
    for (int i = 0; i < 8 && nprReq !== 1'b1; i++)
      @(posedge sys_clk);
    #1 chk({15'h0, nprReq}, 16'h0001);
    @(posedge sys_clk);
    dmaWordReq <= 1'b0;
    nprGrant <= 1'b0;
    $display("dma test done");
  endtask

  // Cuts a hang short.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      testDone();
    end
  end

  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tReset();
    tCmd();
    tEvt();
    tReinit();
    tClash();
    tDma();
    testDone();
  end
endmodule

//--- tb/mpu_model.sv
// Purpose: Microprocessor side of the adapter.
// Assumes: Bench requests are spaced from interrupt service.
// Notes: lag delays the answer to an interrupt.
`timescale 1ns/100ps

module mpu_model
  import hpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mpuIrq,
  input wire logic [DATA_W-1:0] mpuRdata,
  input wire logic [3:0] lag,
  input wire logic opGo,
  input wire logic [BUS_AW-1:0] opAddr,
  input wire logic [DATA_W-1:0] opData,
  output logic [BUS_AW-1:0] mpuAddr,
  output logic [DATA_W-1:0] mpuWdata,
  output logic mpuWr,
  output logic mpuRd,
  output logic [FLAG_W-1:0] seenFlags
);
  logic [1:0] phase_ff;
  logic [3:0] wait_ff;

  // Bench writes go first; else an interrupt is read and cleared.
  always_ff @(posedge sys_clk)
  begin
    mpuWr <= 1'b0;
    mpuRd <= 1'b0;
    mpuWdata <= ~mpuWdata; // Idle data never hold the last value.
    if (sys_rst)
    begin
      phase_ff <= 2'h0;
      wait_ff <= 4'h0;
      seenFlags <= '0;
      mpuAddr <= '0;
      mpuWdata <= '0;
    end
    else if (opGo)
    begin
      mpuWr <= 1'b1;
      mpuAddr <= opAddr;
      mpuWdata <= opData;
    end
    else
      case (phase_ff)
        2'h0:
        begin
          wait_ff <= lag;
          phase_ff <= {1'b0, mpuIrq};
        end
        2'h1:
        begin
          wait_ff <= wait_ff - 4'h1;
          if (wait_ff == 4'h0)
          begin
            mpuRd <= 1'b1;
            mpuAddr <= MPU_FLAGS_OFS;
            phase_ff <= 2'h2;
          end
        end
        2'h2: phase_ff <= 2'h3;
        default:
        begin
          if (|mpuRdata[FLAG_W-1:0])
            seenFlags <= mpuRdata[FLAG_W-1:0];
          mpuWr <= 1'b1;
          mpuAddr <= MPU_FLAGS_OFS;
          mpuWdata <= mpuRdata;
          phase_ff <= 2'h0;
        end
      endcase
  end
endmodule
